/* File: hdl/llfg_map.svh */
// Constants for the link loss fallback guard
// Function
// - Any link fault forces fallback mode
// - Unchanged heartbeat bit is a link fault
// - No valid frame within 32/128 ms
// - Frame bit count not multiple of 16
// - Link failure flag reported after fault
// - Flag holds while in fallback mode
// - Flag cleared on fallback to normal
// - Request and direct inputs deglitched 200 us
// - Filtered fallback request enters fallback mode
// - Filtered direct input drives its channel
// - Reset input deglitched on falling edge
// - PWM clock deglitched 2.0 us, fast fails
// - Clock monitor starts at reset release
// - Slow clock: outputs follow direct control
// - Valid clock: outputs follow PWM duty
// - Clock diag clears after removal and read
// - External switch follows channel 6, normal
// - External switch low in sleep, fallback
// - Fallback: channels follow filtered direct inputs
// - Fallback request level readable as status
`ifndef LLFG_MAP_SVH
`define LLFG_MAP_SVH

`define LLFG_CLK_MHZ 200
`define LLFG_WORD_BITS 16
`define LLFG_HB_BIT 15
`define LLFG_CNT_BITS 8
`define LLFG_NUM_CH 4

`define LLFG_WD_SHORT_MS 32
`define LLFG_WD_LONG_MS 128
`define LLFG_DGL_IN_US 200
`define LLFG_DGL_RST_US 10
`define LLFG_DGL_CLK_US_X10 20
`define LLFG_CLK_LOW_HZ 100

`define LLFG_WD_SHORT_CYC (`LLFG_WD_SHORT_MS * 1000 * `LLFG_CLK_MHZ)
`define LLFG_WD_LONG_CYC (`LLFG_WD_LONG_MS * 1000 * `LLFG_CLK_MHZ)
`define LLFG_DGL_IN_CYC (`LLFG_DGL_IN_US * `LLFG_CLK_MHZ)
`define LLFG_DGL_RST_CYC (`LLFG_DGL_RST_US * `LLFG_CLK_MHZ)
`define LLFG_DGL_CLK_CYC (`LLFG_DGL_CLK_US_X10 * `LLFG_CLK_MHZ / 10)
`define LLFG_CLK_LOW_CYC (`LLFG_CLK_MHZ * 1000000 / `LLFG_CLK_LOW_HZ)

`define LLFG_RST_FILT_INIT 1'b0

`endif

/* File: hdl/llfg_pkg.sv */
// Types for the link loss fallback guard
package llfg_pkg;
    `include "llfg_map.svh"

    typedef enum logic {
        MODE_NORMAL,
        MODE_FALLBACK
    } llfg_mode_t;

    typedef struct packed {
        logic fallback_req;
        logic [`LLFG_NUM_CH-1:0] direct;
    } llfg_filt_t;

    typedef struct packed {
        logic [`LLFG_WORD_BITS-1:0] word;
        logic [`LLFG_CNT_BITS-1:0] count;
    } llfg_frame_t;
endpackage

/* File: hdl/llfg_guard.sv */
// Link loss fallback guard: watchdog, deglitchers and mode control
`timescale 1ns/1ps
module llfg_guard #(
    parameter int WD_SHORT_CYC = `LLFG_WD_SHORT_CYC,
    parameter int WD_LONG_CYC = `LLFG_WD_LONG_CYC,
    parameter int DGL_IN_CYC = `LLFG_DGL_IN_CYC,
    parameter int DGL_RST_CYC = `LLFG_DGL_RST_CYC,
    parameter int DGL_CLK_CYC = `LLFG_DGL_CLK_CYC,
    parameter int CLK_LOW_CYC = `LLFG_CLK_LOW_CYC
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Link from the host
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    // Pins
    input wire logic fallback_request_pin,
    input wire logic [`LLFG_NUM_CH-1:0] direct_channel_input,
    input wire logic active_low_reset_input,
    input wire logic pwm_clock_pin,
    // Configuration and control from the register logic
    input wire logic timeout_select,
    input wire logic ch6_setting,
    input wire logic [`LLFG_NUM_CH-1:0] channel_direct_control,
    input wire logic [`LLFG_NUM_CH-1:0] pwm_channel_on,
    input wire logic sleep_mode,
    input wire logic qs1_read,
    // Status
    output llfg_pkg::llfg_mode_t mode,
    output logic link_failure_flag,
    output logic fallback_request_status,
    output logic clock_fail_live,
    output logic clock_fail_diag,
    output logic reset_filtered_n,
    output llfg_pkg::llfg_filt_t filtered_inputs,
    output llfg_pkg::llfg_frame_t rx_frame,
    output logic frame_done,
    // Drives
    output logic [`LLFG_NUM_CH-1:0] channel_drive,
    output logic external_switch_drive
);
    import llfg_pkg::*;

    localparam int NCH = `LLFG_NUM_CH;
    localparam int WB = `LLFG_WORD_BITS;
    localparam int CB = `LLFG_CNT_BITS;
    localparam int NSYNC = NCH + 4;
    localparam int WDW = $clog2(WD_LONG_CYC + 1);
    localparam int INW = $clog2(DGL_IN_CYC + 1);
    localparam int RSW = $clog2(DGL_RST_CYC + 1);
    localparam int CKW = $clog2(DGL_CLK_CYC + 1);
    localparam int LOW = $clog2(CLK_LOW_CYC + 1);

    // Link clock domain: free bit counter and shifter
    logic link_rst_reg;
    logic [CB-1:0] bit_cnt_reg;
    logic [WB-1:0] shift_reg;

    always_ff @(posedge core_clk) begin
        link_rst_reg <= rst;
    end

    // Async clear only, the link clock is idle during reset
    always_ff @(posedge spi_sclk or posedge link_rst_reg) begin
        if (link_rst_reg) begin
            bit_cnt_reg <= '0;
            shift_reg <= '0;
        end else if (!spi_cs_n) begin
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            shift_reg <= {shift_reg[WB-2:0], spi_mosi};
        end
    end

    // Pin synchronisers
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    wire [NSYNC-1:0] raw_pins = {spi_cs_n, pwm_clock_pin,
        active_low_reset_input, fallback_request_pin, direct_channel_input};

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync1_reg <= {1'b1, {(NSYNC-1){1'b0}}};
            sync2_reg <= {1'b1, {(NSYNC-1){1'b0}}};
        end else begin
            sync1_reg <= raw_pins;
            sync2_reg <= sync1_reg;
        end
    end

    wire [NCH-1:0] in_s = sync2_reg[NCH-1:0];
    wire req_s = sync2_reg[NCH];
    wire rstn_s = sync2_reg[NCH+1];
    wire pclk_s = sync2_reg[NCH+2];
    wire cs_s = sync2_reg[NCH+3];

    // Symmetric deglitch for request and direct inputs
    wire [NCH:0] sym_raw = {req_s, in_s};
    logic [NCH:0] sym_filt;

    genvar gi;
    generate
        for (gi = 0; gi <= NCH; gi++) begin : g_dgl
            logic [INW-1:0] cnt_reg;
            logic filt_reg;
            wire differs = sym_raw[gi] != filt_reg;
            wire term = cnt_reg == INW'(DGL_IN_CYC - 1);
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    cnt_reg <= '0;
                    filt_reg <= 1'b0;
                end else if (!differs) begin
                    cnt_reg <= '0;
                end else if (term) begin
                    cnt_reg <= '0;
                    filt_reg <= sym_raw[gi];
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end
            assign sym_filt[gi] = filt_reg;
        end
    endgenerate

    // Request sits above the direct bits, as in the struct
    assign filtered_inputs = llfg_filt_t'(sym_filt);

    // Reset input: falling edges filtered, rising edges immediate
    logic [RSW-1:0] rcnt_reg;
    logic rfilt_reg;
    wire rst_term = rcnt_reg == RSW'(DGL_RST_CYC - 1);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rcnt_reg <= '0;
            rfilt_reg <= `LLFG_RST_FILT_INIT;
        end else if (rstn_s) begin
            rcnt_reg <= '0;
            rfilt_reg <= 1'b1;
        end else if (!rfilt_reg) begin
            rcnt_reg <= '0;
        end else if (rst_term) begin
            rcnt_reg <= '0;
            rfilt_reg <= 1'b0;
        end else begin
            rcnt_reg <= rcnt_reg + 1'b1;
        end
    end

    assign reset_filtered_n = rfilt_reg;
    wire soft_rst = !rfilt_reg;

    // PWM clock deglitch; a too fast clock never passes
    logic [CKW-1:0] ccnt_reg;
    logic cfilt_reg;
    logic cfilt_prev_reg;
    wire clk_term = ccnt_reg == CKW'(DGL_CLK_CYC - 1);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ccnt_reg <= '0;
            cfilt_reg <= 1'b0;
            cfilt_prev_reg <= 1'b0;
        end else begin
            cfilt_prev_reg <= cfilt_reg;
            if (pclk_s == cfilt_reg) begin
                ccnt_reg <= '0;
            end else if (clk_term) begin
                ccnt_reg <= '0;
                cfilt_reg <= pclk_s;
            end else begin
                ccnt_reg <= ccnt_reg + 1'b1;
            end
        end
    end

    wire pclk_rise = cfilt_reg && !cfilt_prev_reg;

    // Clock low frequency monitor
    logic [LOW-1:0] per_cnt_reg;
    logic live_reg;
    logic diag_reg;
    wire per_term = per_cnt_reg == LOW'(CLK_LOW_CYC - 1);

    always_ff @(posedge core_clk) begin
        if (rst || soft_rst) begin
            per_cnt_reg <= '0;
            live_reg <= 1'b0;
        end else if (pclk_rise) begin
            per_cnt_reg <= '0;
            live_reg <= 1'b0;
        end else if (per_term) begin
            live_reg <= 1'b1;
        end else begin
            per_cnt_reg <= per_cnt_reg + 1'b1;
        end
    end

    // Latched diagnosis: set wins over the clearing read
    always_ff @(posedge core_clk) begin
        if (rst) begin
            diag_reg <= 1'b0;
        end else if (live_reg) begin
            diag_reg <= 1'b1;
        end else if (qs1_read) begin
            diag_reg <= 1'b0;
        end
    end

    assign clock_fail_live = live_reg;
    assign clock_fail_diag = diag_reg;

    // Frame end seen in core domain; link data is then static
    logic cs_prev_reg;
    logic [CB-1:0] prev_cnt_reg;
    logic prev_hb_reg;
    logic hb_valid_reg;
    llfg_frame_t frame_reg;
    logic done_reg;

    wire frame_end = cs_s && !cs_prev_reg;
    wire [CB-1:0] frame_len = bit_cnt_reg - prev_cnt_reg;
    wire any_bits = frame_len != '0;
    wire len_err = frame_end && frame_len[3:0] != 4'h0;
    wire hb_now = shift_reg[`LLFG_HB_BIT];
    wire hb_err = frame_end && any_bits && hb_valid_reg
        && (hb_now == prev_hb_reg);
    wire good_frame = frame_end && any_bits && !len_err && !hb_err;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cs_prev_reg <= 1'b1;
            prev_cnt_reg <= '0;
            prev_hb_reg <= 1'b0;
            hb_valid_reg <= 1'b0;
            frame_reg <= '0;
            done_reg <= 1'b0;
        end else begin
            cs_prev_reg <= cs_s;
            done_reg <= frame_end && any_bits;
            if (frame_end) begin
                prev_cnt_reg <= bit_cnt_reg;
            end
            if (frame_end && any_bits) begin
                prev_hb_reg <= hb_now;
                hb_valid_reg <= 1'b1;
                frame_reg.word <= shift_reg;
                frame_reg.count <= frame_len;
            end
        end
    end

    assign rx_frame = frame_reg;
    assign frame_done = done_reg;

    // Watchdog on valid frames
    logic [WDW-1:0] wd_cnt_reg;
    wire [WDW-1:0] wd_limit = timeout_select ? WDW'(WD_LONG_CYC - 1)
        : WDW'(WD_SHORT_CYC - 1);
    wire wd_err = wd_cnt_reg >= wd_limit;

    always_ff @(posedge core_clk) begin
        if (rst || soft_rst || good_frame || wd_err) begin
            wd_cnt_reg <= '0;
        end else begin
            wd_cnt_reg <= wd_cnt_reg + 1'b1;
        end
    end

    wire link_fault = !soft_rst && (hb_err || len_err || wd_err);

    // Operating mode
    llfg_mode_t mode_reg;
    llfg_mode_t mode_next;

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            MODE_NORMAL: begin
                if (link_fault || filtered_inputs.fallback_req) begin
                    mode_next = MODE_FALLBACK;
                end
            end
            MODE_FALLBACK: begin
                if (!filtered_inputs.fallback_req && good_frame
                        && !link_fault) begin
                    mode_next = MODE_NORMAL;
                end
            end
            default: begin
                mode_next = MODE_NORMAL;
            end
        endcase
        if (soft_rst) begin
            mode_next = MODE_NORMAL;
        end
    end

    wire leave_fallback = mode_reg == MODE_FALLBACK
        && mode_next == MODE_NORMAL;

    // Link failure flag: a fault wins over the clearing transition
    logic flag_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_reg <= MODE_NORMAL;
            flag_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            if (link_fault) begin
                flag_reg <= 1'b1;
            end else if (leave_fallback) begin
                flag_reg <= 1'b0;
            end
        end
    end

    assign mode = mode_reg;
    assign link_failure_flag = flag_reg;

    // Output drives
    wire in_fallback = mode_reg == MODE_FALLBACK;
    wire [NCH-1:0] normal_src = live_reg ? channel_direct_control
        : pwm_channel_on;
    wire [NCH-1:0] drive_next = in_fallback ? filtered_inputs.direct
        : normal_src;
    wire ext_next = !in_fallback && !sleep_mode
        && ch6_setting;

    logic [NCH-1:0] drive_reg;
    logic ext_reg;
    logic req_stat_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            drive_reg <= '0;
            ext_reg <= 1'b0;
            req_stat_reg <= 1'b0;
        end else begin
            drive_reg <= drive_next;
            ext_reg <= ext_next;
            req_stat_reg <= req_s;
        end
    end

    assign channel_drive = drive_reg;
    assign external_switch_drive = ext_reg;
    assign fallback_request_status = req_stat_reg;
endmodule

/* File: testbench/llfg_host.sv */
// Host model driving the serial link frames
`timescale 1ns/1ps
module llfg_host (
    // Link pins
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi
);
    logic hb = 1'b0;

    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b1;
    end

    // Last 16 bits carry the word; keep repeats the heartbeat on purpose
    task automatic send(input logic [15:0] w, input int nb, input bit keep,
            output logic [15:0] sent);
        if (!keep) begin
            hb = ~hb;
        end
        sent = {hb, w[14:0]};
        #8 spi_cs_n = 1'b0;
        for (int j = nb - 1; j >= 0; j--) begin
            spi_mosi = (j < 16) ? sent[j] : 1'b0;
            #16 spi_sclk = 1'b1;
            #16 spi_sclk = 1'b0;
        end
        #16 spi_cs_n = 1'b1;
        // Released line must not keep the last bit
        spi_mosi = ~spi_mosi;
        #97;
    endtask
endmodule

/* File: testbench/llfg_guard_assertions.sv */
// Assertions for the link loss fallback guard
`timescale 1ns/1ps
module llfg_guard_assertions
    import llfg_pkg::*;
#(
    parameter int DGL_IN_CYC = 20
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Inputs
    input wire logic sleep_mode,
    input wire logic ch6_setting,
    input wire logic fallback_request_pin,
    input wire logic [3:0] channel_direct_control,
    input wire logic [3:0] pwm_channel_on,
    input wire logic qs1_read,
    // Outputs
    input wire llfg_pkg::llfg_mode_t mode,
    input wire logic link_failure_flag,
    input wire logic clock_fail_live,
    input wire logic clock_fail_diag,
    input wire llfg_pkg::llfg_filt_t filtered_inputs,
    input wire logic frame_done,
    input wire logic [3:0] channel_drive,
    input wire logic external_switch_drive
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_ext_switch_follow: assert property (1'b1 |=>
        external_switch_drive == ($past(mode) == MODE_NORMAL
        && !$past(sleep_mode) && $past(ch6_setting)))
        else $error("external switch drive wrong");
    a_flag_retained: assert property (
        (link_failure_flag && mode == MODE_FALLBACK)
        ##1 (mode == MODE_FALLBACK) |-> link_failure_flag)
        else $error("link failure flag lost in fallback");
    a_flag_cleared: assert property (
        (mode == MODE_FALLBACK) ##1 (mode == MODE_NORMAL)
        |-> !link_failure_flag)
        else $error("link failure flag kept after return");
    a_fault_fallback: assert property (
        $rose(link_failure_flag) |-> mode == MODE_FALLBACK)
        else $error("link fault without fallback");
    a_fb_channels: assert property (mode == MODE_FALLBACK |=>
        channel_drive == $past(filtered_inputs.direct))
        else $error("fallback drive not from filtered inputs");
    a_slow_direct: assert property (
        mode == MODE_NORMAL && clock_fail_live |=>
        channel_drive == $past(channel_direct_control))
        else $error("failed clock drive not direct");
    a_valid_pwm: assert property (
        mode == MODE_NORMAL && !clock_fail_live |=>
        channel_drive == $past(pwm_channel_on))
        else $error("valid clock drive not from duty");
    a_diag_latched: assert property (
        clock_fail_live || (clock_fail_diag && !qs1_read)
        |=> clock_fail_diag)
        else $error("clock diagnosis dropped early");
    a_req_deglitch: assert property (
        $rose(filtered_inputs.fallback_req)
        |-> $past(fallback_request_pin, DGL_IN_CYC))
        else $error("request filter passed a short pulse");

    c_link_fault: cover property ($rose(link_failure_flag));
    c_frame: cover property (frame_done);
    c_diag_clear: cover property ($fell(clock_fail_diag));
endmodule

bind llfg_guard llfg_guard_assertions #(.DGL_IN_CYC(DGL_IN_CYC))
    llfg_guard_assertions_inst (.core_clk, .rst, .sleep_mode, .ch6_setting,
    .fallback_request_pin, .channel_direct_control, .pwm_channel_on,
    .qs1_read, .mode, .link_failure_flag, .clock_fail_live,
    .clock_fail_diag, .filtered_inputs, .frame_done, .channel_drive,
    .external_switch_drive);

/* File: testbench/llfg_guard_tb_top.sv */
// Testbench for the link loss fallback guard
`timescale 1ns/1ps
// Outputs compared 1 ns past the edge; a check ends on the next edge
`define CHK(n, e, g) begin #1; total_checks++; if ((g) !== (e)) begin \
    fails++; $display("[ERR] %s exp %0h got %0h", n, e, g); end \
    @(posedge core_clk); end
`define WAITHI(s, lim) begin @(negedge core_clk); \
    for (int k = 0; k < lim && (s) !== 1'b1; k++) @(negedge core_clk); \
    if ((s) !== 1'b1) begin fails++; complete_run(); end \
    @(posedge core_clk); end
module llfg_guard_tb_top;
    import llfg_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic fallback_request_pin = 1'b0;
    logic active_low_reset_input = 1'b1;
    logic pwm_clock_pin = 1'b0;
    logic timeout_select = 1'b0;
    logic ch6_setting = 1'b0;
    logic sleep_mode = 1'b0;
    logic qs1_read = 1'b0;
    logic [3:0] direct_channel_input = 4'h0;
    logic [3:0] channel_direct_control = 4'h5;
    logic [3:0] pwm_channel_on = 4'ha;
    wire spi_sclk, spi_cs_n, spi_mosi;
    llfg_mode_t mode;
    llfg_filt_t filtered_inputs;
    llfg_frame_t rx_frame;
    logic link_failure_flag, fallback_request_status, clock_fail_live;
    logic clock_fail_diag, reset_filtered_n, frame_done;
    logic external_switch_drive;
    logic [3:0] channel_drive;
    logic [15:0] sent;
    int fails = 0;
    int total_checks = 0;
    int done_cnt = 0;

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    // Counts frame capture pulses
    always @(posedge core_clk) begin
        if (frame_done === 1'b1) begin
            done_cnt <= done_cnt + 1;
        end
    end

    // Reset filter left at its default length
    llfg_guard #(.WD_SHORT_CYC(1000), .WD_LONG_CYC(4000), .DGL_IN_CYC(20),
        .DGL_CLK_CYC(4), .CLK_LOW_CYC(200))
        llfg_guard_inst (.core_clk, .rst, .spi_sclk, .spi_cs_n, .spi_mosi,
        .fallback_request_pin, .direct_channel_input,
        .active_low_reset_input, .pwm_clock_pin, .timeout_select,
        .ch6_setting, .channel_direct_control, .pwm_channel_on,
        .sleep_mode, .qs1_read, .mode, .link_failure_flag,
        .fallback_request_status, .clock_fail_live, .clock_fail_diag,
        .reset_filtered_n, .filtered_inputs, .rx_frame, .frame_done,
        .channel_drive, .external_switch_drive);
    llfg_host llfg_host_inst (.spi_sclk, .spi_cs_n, .spi_mosi);

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic frame(input logic [15:0] w, input int nb, input bit keep,
            input logic f);
        int done_before;
        done_before = done_cnt;
        llfg_host_inst.send(w, nb, keep, sent);
        cyc(2);
        `CHK("flag", f, link_failure_flag)
        `CHK("mode", f ? MODE_FALLBACK : MODE_NORMAL, mode)
        `CHK("count", 8'(nb), rx_frame.count)
        `CHK("word", sent, rx_frame.word)
        `CHK("done", done_before + 1, done_cnt)
    endtask

    task automatic qs1_pulse();
        qs1_read <= 1'b1;
        cyc(1);
        qs1_read <= 1'b0;
        cyc(2);
    endtask

    initial begin
        cyc(4);
        rst <= 1'b0;
        ch6_setting <= 1'b1;
        cyc(6);
        `CHK("soft reset", 1'b1, reset_filtered_n)
        frame(16'h1234, 16, 0, 0);
        frame(16'h8abc, 32, 0, 0);
        `CHK("ext on", 1'b1, external_switch_drive)
        sleep_mode <= 1'b1;
        cyc(2);
        `CHK("ext sleep", 1'b0, external_switch_drive)
        sleep_mode <= 1'b0;
        frame(16'h5555, 16, 1, 1);
        `CHK("ext fallback", 1'b0, external_switch_drive)
        frame(16'h2222, 16, 1, 1);
        frame(16'h3333, 16, 0, 0);
        frame(16'h4444, 17, 0, 1);
        frame(16'h6666, 16, 0, 0);
        cyc(900);
        `CHK("wd early", 1'b0, link_failure_flag)
        `WAITHI(link_failure_flag, 200)
        timeout_select <= 1'b1;
        frame(16'h0101, 16, 0, 0);
        cyc(3800);
        `CHK("wd long early", 1'b0, link_failure_flag)
        `WAITHI(link_failure_flag, 400)
        frame(16'h0202, 16, 0, 0);
        `CHK("live at start", 1'b1, clock_fail_live)
        `CHK("drive direct", 4'h5, channel_drive)
        qs1_pulse();
        `CHK("diag held", 1'b1, clock_fail_diag)
        repeat (30) begin
            pwm_clock_pin <= ~pwm_clock_pin;
            cyc(10);
        end
        `CHK("live clear", 1'b0, clock_fail_live)
        `CHK("drive pwm", 4'ha, channel_drive)
        `CHK("diag kept", 1'b1, clock_fail_diag)
        qs1_pulse();
        `CHK("diag clear", 1'b0, clock_fail_diag)
        repeat (260) begin
            pwm_clock_pin <= ~pwm_clock_pin;
            cyc(1);
        end
        `CHK("fast clock", 1'b1, clock_fail_live)
        frame(16'h0303, 16, 0, 0);
        direct_channel_input <= 4'h9;
        fallback_request_pin <= 1'b1;
        cyc(8);
        fallback_request_pin <= 1'b0;
        cyc(30);
        `CHK("glitch ignored", MODE_NORMAL, mode)
        fallback_request_pin <= 1'b1;
        cyc(5);
        `CHK("request status", 1'b1, fallback_request_status)
        cyc(25);
        `CHK("request fallback", MODE_FALLBACK, mode)
        `CHK("drive filtered", 4'h9, channel_drive)
        direct_channel_input <= 4'hf;
        cyc(8);
        direct_channel_input <= 4'h9;
        cyc(30);
        `CHK("direct glitch", 4'h9, channel_drive)
        direct_channel_input <= 4'h6;
        cyc(30);
        `CHK("drive new", 4'h6, channel_drive)
        fallback_request_pin <= 1'b0;
        cyc(30);
        frame(16'h0404, 16, 0, 0);
        active_low_reset_input <= 1'b0;
        cyc(5);
        active_low_reset_input <= 1'b1;
        cyc(4);
        `CHK("reset glitch", 1'b1, reset_filtered_n)
        active_low_reset_input <= 1'b0;
        cyc(2010);
        `CHK("reset taken", 1'b0, reset_filtered_n)
        active_low_reset_input <= 1'b1;
        cyc(4);
        `CHK("reset release", 1'b1, reset_filtered_n)
        `CHK("live restart", 1'b0, clock_fail_live)
        `WAITHI(clock_fail_live, 260)
        complete_run();
    end
endmodule
